// ### logic/disp_pkg.sv
// constants, field layout and types shared by the panel pin engine
//
// How it works
// - disable done is flagged only once the engine is off and the frame on the pins has ended.
// - with the disable done mask at 0 a set disable done flag raises its request.
// - with the disable done mask at 1 the disable done request stays low.
// - the disable done mask never changes the flag nor how hardware sets and clears it.
// - each frame start loads the current address from the base address and sets base update.
// - with the base update mask at 0 a set base update flag raises its request.
// - with the base update mask at 1 the base update request stays low.
// - the base update mask never changes the flag nor how hardware sets and clears it.
// - colour dual panel drives upper rows on the data pins, lower rows on gpio 9..2, first on 9.
// - clearing enable lets the current frame finish, then the engine stops and flags done.
package disp_pkg;
   // register byte offsets
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] STAT_OFF = 8'h04;
   localparam logic [7:0] BASE_OFF = 8'h08;
   localparam logic [7:0] CUR_OFF = 8'h0C;
   localparam logic [7:0] GEOM_OFF = 8'h10;
   localparam logic [7:0] DATA_OFF = 8'h14;
   // display_control_register_zero fields
   localparam int EN_BIT = 0;
   localparam int MODE_LSB = 1;
   localparam int DD_MASK_BIT = 3;
   localparam int BU_MASK_BIT = 4;
   localparam int CTRL_W = 5;
   localparam logic [4:0] CTRL_RST = 5'h00;
   // display_status_register fields
   localparam int DD_FLAG_BIT = 0;
   localparam int BU_FLAG_BIT = 1;
   localparam int RUN_BIT = 2;
   // geometry: words per line low half, lines per frame high half
   localparam logic [31:0] GEOM_RST = 32'h00F0_0050;
   localparam logic [31:0] ADDR_STEP = 32'h0000_0004;
   // pixel path
   localparam int PIX_W = 16;
   localparam int FIFO_DEPTH = 32;
   typedef enum logic [1:0] {
      MODE_MONO4, MODE_MONO_DUAL, MODE_COLOR, MODE_COLOR_DUAL
   } pin_mode_e;
   typedef enum logic {ST_IDLE, ST_ACTIVE} frame_state_e;
endpackage

// ### logic/display_pin_engine.sv
// pixel fifo and panel pin engine with apb registers
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module pix_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // fill side
   input wire logic in_vld,
   output logic in_rdy,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_vld,
   input wire logic out_rdy,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg, rd_ptr_reg;
   logic [AW:0] count_reg;
   logic push, pop;

   // honest full and empty straight from the fill count
   assign in_rdy = count_reg != (AW+1)'(DEPTH);
   assign out_vld = count_reg != '0;
   assign out_data = mem[rd_ptr_reg];
   assign push = in_vld & in_rdy;
   assign pop = out_vld & out_rdy;

   // storage has no reset, only pointers and the fill count need one
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   // pointers wrap at the depth, which need not be a power of two
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

module display_pin_engine #(
   parameter int DEPTH = disp_pkg::FIFO_DEPTH
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // apb slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // panel pins
   output logic [7:0] display_data_pins,
   output logic display_data_oe_b,
   output logic [7:0] gpio_out,
   output logic gpio_oe_b,
   output logic pixel_strobe,
   output logic frame_sync,
   // requests to the interrupt controller
   output logic disable_done_irq,
   output logic base_update_irq
);
   import disp_pkg::*;

   logic [CTRL_W-1:0] ctrl_reg;
   logic [31:0] base_reg, cur_reg, geom_reg, prdata_reg, rd_mux;
   logic disable_done_flag_reg, base_update_flag_reg, gpio_oe_b_reg;
   logic strobe_reg, sync_reg, setup, access, mapped, data_hit, wr_en;
   logic fifo_in_rdy, fifo_vld, shift, last_shift, frame_start, done_set;
   logic display_enable_bit, disable_done_irq_mask, base_update_irq_mask;
   logic [15:0] col_reg, row_reg;
   frame_state_e state_reg;
   logic [7:0] pins_reg, gpio_reg;
   logic [PIX_W-1:0] word;
   pin_mode_e mode;

   assign display_enable_bit = ctrl_reg[EN_BIT];
   assign disable_done_irq_mask = ctrl_reg[DD_MASK_BIT];
   assign base_update_irq_mask = ctrl_reg[BU_MASK_BIT];
   assign mode = pin_mode_e'(ctrl_reg[MODE_LSB +: 2]);

   // apb decode; a full fifo holds pready low so the writer stalls
   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign data_hit = paddr == DATA_OFF;
   assign mapped = paddr inside {CTRL_OFF, STAT_OFF, BASE_OFF, CUR_OFF,
                                 GEOM_OFF, DATA_OFF};
   assign pready = ~(pwrite & data_hit & ~fifo_in_rdy);
   assign pslverr = access & ~mapped;
   assign wr_en = access & pwrite & pready & mapped;
   assign prdata = prdata_reg;

   // read mux; the data port is write only and reads zero
   always_comb begin
      rd_mux = '0;
      case (paddr)
         CTRL_OFF: rd_mux[CTRL_W-1:0] = ctrl_reg;
         STAT_OFF: begin
            rd_mux[DD_FLAG_BIT] = disable_done_flag_reg;
            rd_mux[BU_FLAG_BIT] = base_update_flag_reg;
            rd_mux[RUN_BIT] = state_reg == ST_ACTIVE;
         end
         BASE_OFF: rd_mux = base_reg;
         CUR_OFF: rd_mux = cur_reg;
         GEOM_OFF: rd_mux = geom_reg;
         default: rd_mux = '0;
      endcase
   end

   // read data caught in the setup cycle keeps the access zero wait
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata_reg <= '0;
      end else if (setup & ~pwrite) begin
         prdata_reg <= rd_mux;
      end
   end

   // software registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_reg <= CTRL_RST;
         base_reg <= '0;
         geom_reg <= GEOM_RST;
      end else if (wr_en) begin
         case (paddr)
            CTRL_OFF: ctrl_reg <= pwdata[CTRL_W-1:0];
            BASE_OFF: base_reg <= pwdata;
            GEOM_OFF: geom_reg <= pwdata;
            default: ;
         endcase
      end
   end

   pix_fifo #(.WIDTH(PIX_W), .DEPTH(DEPTH)) u_fifo (
      .clk(clk),
      .rst_b(rst_b),
      .in_vld(wr_en & data_hit),
      .in_rdy(fifo_in_rdy),
      .in_data(pwdata[PIX_W-1:0]),
      .out_vld(fifo_vld),
      .out_rdy(state_reg == ST_ACTIVE),
      .out_data(word)
   );

   // one fifo word leaves per shift; an empty fifo stalls the raster
   assign shift = (state_reg == ST_ACTIVE) & fifo_vld;
   assign last_shift = shift & (col_reg == geom_reg[15:0] - 16'h0001)
                     & (row_reg == geom_reg[31:16] - 16'h0001);
   assign frame_start = display_enable_bit &
                        ((state_reg == ST_IDLE) | last_shift);
   assign done_set = last_shift & ~display_enable_bit;

   // frame sequencer: enable is looked at only on frame boundaries
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= ST_IDLE;
      end else begin
         case (state_reg)
            ST_IDLE: if (display_enable_bit) state_reg <= ST_ACTIVE;
            ST_ACTIVE: if (done_set) state_reg <= ST_IDLE;
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // column and line counters
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         col_reg <= '0;
         row_reg <= '0;
      end else if (state_reg == ST_IDLE) begin
         col_reg <= '0;
         row_reg <= '0;
      end else if (shift) begin
         if (col_reg == geom_reg[15:0] - 16'h0001) begin
            col_reg <= '0;
            row_reg <= last_shift ? 16'h0000 : row_reg + 16'h0001;
         end else begin
            col_reg <= col_reg + 16'h0001;
         end
      end
   end

   // current address reloads at each frame start, steps per word
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cur_reg <= '0;
      end else if (frame_start) begin
         cur_reg <= base_reg;
      end else if (shift) begin
         cur_reg <= cur_reg + ADDR_STEP;
      end
   end

   // sticky flags, write one to clear; a set in the same cycle wins
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         disable_done_flag_reg <= 1'b0;
         base_update_flag_reg <= 1'b0;
      end else begin
         // masks play no part here, only in the requests
         if (done_set) begin
            disable_done_flag_reg <= 1'b1;
         end else if (wr_en && paddr == STAT_OFF && pwdata[DD_FLAG_BIT]) begin
            disable_done_flag_reg <= 1'b0;
         end
         if (frame_start) begin
            base_update_flag_reg <= 1'b1;
         end else if (wr_en && paddr == STAT_OFF && pwdata[BU_FLAG_BIT]) begin
            base_update_flag_reg <= 1'b0;
         end
      end
   end

   // masks gate only the requests
   assign disable_done_irq = disable_done_flag_reg & ~disable_done_irq_mask;
   assign base_update_irq = base_update_flag_reg & ~base_update_irq_mask;

   // pin formatter; pins hold their value between shifts
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pins_reg <= '0;
         gpio_reg <= '0;
      end else if (shift) begin
         case (mode)
            MODE_MONO4: begin
               pins_reg <= {4'h0, word[3:0]};
               gpio_reg <= '0;
            end
            MODE_MONO_DUAL: begin
               pins_reg <= {word[11:8], word[3:0]};
               gpio_reg <= '0;
            end
            MODE_COLOR: begin
               pins_reg <= word[7:0];
               gpio_reg <= '0;
            end
            MODE_COLOR_DUAL: begin
               pins_reg <= word[7:0];
               gpio_reg <= word[15:8];
            end
            default: begin
               pins_reg <= '0;
               gpio_reg <= '0;
            end
         endcase
      end
   end

   // pin ownership and strobes; idle hands pins back to the pin unit
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         gpio_oe_b_reg <= 1'b1;
         strobe_reg <= 1'b0;
         sync_reg <= 1'b0;
      end else begin
         gpio_oe_b_reg <= ~(state_reg == ST_ACTIVE && mode == MODE_COLOR_DUAL);
         strobe_reg <= shift;
         sync_reg <= frame_start;
      end
   end

   assign display_data_pins = pins_reg;
   assign display_data_oe_b = state_reg != ST_ACTIVE;
   assign gpio_out = gpio_reg;
   assign gpio_oe_b = gpio_oe_b_reg;
   assign pixel_strobe = strobe_reg;
   assign frame_sync = sync_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence s_frame_end_off;
      last_shift && !display_enable_bit;
   endsequence
   sequence s_stopped_done;
      state_reg == ST_IDLE && disable_done_flag_reg;
   endsequence

   a_done_cause: assert property ($rose(disable_done_flag_reg) |->
      $past(last_shift) && !$past(display_enable_bit))
      else $error("disable done set without a finished frame");
   a_done_irq_on: assert property (disable_done_flag_reg &&
      !disable_done_irq_mask |-> disable_done_irq)
      else $error("unmasked disable done gave no request");
   a_done_irq_off: assert property (disable_done_irq_mask |->
      !disable_done_irq ##1 (!disable_done_irq || !disable_done_irq_mask))
      else $error("masked disable done raised a request");
   a_done_mask_keep: assert property ($changed(disable_done_irq_mask) &&
      disable_done_flag_reg |-> $past(disable_done_flag_reg))
      else $error("disable done mask changed the flag");
   a_base_load: assert property (frame_start |=>
      cur_reg == $past(base_reg) && base_update_flag_reg)
      else $error("frame start did not load the address");
   a_base_irq_on: assert property (base_update_flag_reg &&
      !base_update_irq_mask |-> base_update_irq)
      else $error("unmasked base update gave no request");
   a_base_irq_off: assert property (base_update_irq_mask |->
      !base_update_irq)
      else $error("masked base update raised a request");
   a_base_mask_keep: assert property (frame_start &&
      base_update_irq_mask |=> base_update_flag_reg)
      else $error("masked base update flag not set");
   a_dual_pins: assert property (shift && mode == MODE_COLOR_DUAL |=>
      gpio_out == $past(word[15:8]) && !gpio_oe_b)
      else $error("lower rows missing from gpio pins");
   a_color_pins: assert property (shift && mode == MODE_COLOR |=>
      display_data_pins == $past(word[7:0]))
      else $error("colour components out of order");
   a_mono_pins: assert property (shift && mode == MODE_MONO4 |=>
      display_data_pins == {4'h0, $past(word[3:0])})
      else $error("mono pixels on the wrong pins");
   a_finish_frame: assert property (s_frame_end_off |=> s_stopped_done)
      else $error("engine did not stop after its last frame");
endmodule

`default_nettype wire

// ### sim/panel_model.sv
// panel side model: latches each word the engine presents on its pins
`timescale 1ns/1ps
`default_nettype none

module panel_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // pins from the engine
   input wire logic [7:0] display_data_pins,
   input wire logic [7:0] gpio_out,
   input wire logic pixel_strobe,
   // what the panel took
   output logic [7:0] last_pins,
   output logic [7:0] last_gpio,
   output logic [15:0] words
);
   // a real panel only looks at the data lines on a strobe, so do the same
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         last_pins <= 8'h00;
         last_gpio <= 8'h00;
         words <= 16'h0000;
      end else if (pixel_strobe) begin
         last_pins <= display_data_pins;
         last_gpio <= gpio_out;
         words <= words + 16'h0001;
      end
   end
endmodule

`default_nettype wire

// ### sim/lcd_pin_order_and_irq_masks_tb.sv
// self-checking bench for the panel pin engine
`timescale 1ns/1ps
`default_nettype none

module lcd_pin_order_and_irq_masks_tb;
   import disp_pkg::*;
   logic clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
   logic dd_irq, bu_irq, oe_b, gpio_oe_b, strobe, fsync;
   logic [7:0] paddr, pins, gpio, last_pins, last_gpio;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] words;
   int mismatches, checked, nw;
   int syncs = 0;

   display_pin_engine #(.DEPTH(FIFO_DEPTH)) uut (.clk(clk), .rst_b(rst_b),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .display_data_pins(pins), .display_data_oe_b(oe_b), .gpio_out(gpio),
      .gpio_oe_b(gpio_oe_b), .pixel_strobe(strobe), .frame_sync(fsync),
      .disable_done_irq(dd_irq), .base_update_irq(bu_irq));

   panel_model panel (.clk(clk), .rst_b(rst_b), .display_data_pins(pins),
      .gpio_out(gpio), .pixel_strobe(strobe), .last_pins(last_pins),
      .last_gpio(last_gpio), .words(words));

   // frame sync pulses seen at the pins, one per frame start
   always @(posedge clk) begin
      if (rst_b === 1'b1 && fsync === 1'b1) begin
         syncs <= syncs + 1;
      end
   end

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task end_of_test;
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // one apb transfer; pready, prdata and pslverr are all taken at the
   // rising edge that completes the access, and only then is it released
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 500);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk(32'(n < 500), 32'h1, "apb answer");
   endtask

   // bounded wait for the panel to take word number n
   task wait_word(input int n);
      int k;
      k = 0;
      while (words !== 16'(n) && k < 100) begin
         @(negedge clk);
         k++;
      end
      chk(32'(words), 32'(n), "panel word count");
   endtask

   // bounded wait for the engine to let go of the pins
   task wait_off;
      int k;
      k = 0;
      while (oe_b !== 1'b1 && k < 100) begin
         @(negedge clk);
         k++;
      end
      chk({31'h0, oe_b}, 32'h1, "pins not released");
   endtask

   task s_reset;
      apb(1'b0, CTRL_OFF, 32'h0);
      chk(rd, {27'h0, CTRL_RST}, "ctrl reset");
      apb(1'b0, GEOM_OFF, 32'h0);
      chk(rd, GEOM_RST, "geom reset");
      apb(1'b0, STAT_OFF, 32'h0);
      chk(rd, 32'h0, "status reset");
      apb(1'b0, 8'h20, 32'h0);
      chk({31'h0, err}, 32'h1, "unmapped error");
      chk(rd, 32'h0, "unmapped read");
      chk({31'h0, oe_b}, 32'h1, "pins released");
   endtask

   task s_base_update;
      apb(1'b1, GEOM_OFF, 32'h0001_0002);
      apb(1'b1, BASE_OFF, 32'h0000_1000);
      apb(1'b1, CTRL_OFF, 32'h0000_0001);
      apb(1'b0, STAT_OFF, 32'h0);
      chk({31'h0, rd[BU_FLAG_BIT]}, 32'h1, "base flag");
      chk({31'h0, bu_irq}, 32'h1, "base irq open");
      chk(32'(syncs), 32'h1, "frame sync");
      apb(1'b0, CUR_OFF, 32'h0);
      chk(rd, 32'h0000_1000, "current loaded");
      apb(1'b1, CTRL_OFF, 32'h0000_0011);
      apb(1'b0, STAT_OFF, 32'h0);
      chk({31'h0, bu_irq}, 32'h0, "base irq masked");
      chk({31'h0, rd[BU_FLAG_BIT]}, 32'h1, "base flag kept");
      apb(1'b1, STAT_OFF, 32'h0000_0002);
      apb(1'b0, STAT_OFF, 32'h0);
      chk({31'h0, rd[BU_FLAG_BIT]}, 32'h0, "base flag clear");
      apb(1'b1, CTRL_OFF, 32'h0000_0001);
   endtask

   task s_disable;
      apb(1'b1, DATA_OFF, 32'h0000_0005);
      nw++;
      wait_word(nw);
      chk({28'h0, last_pins[3:0]}, 32'h5, "mono4 nibble");
      // enable off mid-frame with the done request masked
      apb(1'b1, CTRL_OFF, 32'h0000_0008);
      apb(1'b0, STAT_OFF, 32'h0);
      chk({31'h0, rd[DD_FLAG_BIT]}, 32'h0, "done too early");
      chk({31'h0, oe_b}, 32'h0, "frame still driven");
      apb(1'b1, DATA_OFF, 32'h0000_000A);
      nw++;
      wait_word(nw);
      wait_off;
      apb(1'b0, STAT_OFF, 32'h0);
      chk(rd, 32'h0000_0001, "done after frame");
      apb(1'b0, CUR_OFF, 32'h0);
      chk(rd, 32'h0000_1000 + 2 * ADDR_STEP, "current stepped");
      chk({31'h0, dd_irq}, 32'h0, "done irq masked");
      apb(1'b1, CTRL_OFF, 32'h0000_0000);
      apb(1'b0, STAT_OFF, 32'h0);
      chk({31'h0, rd[DD_FLAG_BIT]}, 32'h1, "done flag kept");
      chk({31'h0, dd_irq}, 32'h1, "done irq open");
      apb(1'b1, STAT_OFF, 32'h0000_0001);
      apb(1'b0, STAT_OFF, 32'h0);
      chk({31'h0, dd_irq}, 32'h0, "done irq gone");
   endtask

   // every pin mode: one frame of two words, then a clean stop
   task s_modes;
      logic [7:0] mask [4];
      logic [7:0] exp [4];
      mask = '{8'h0F, 8'hFF, 8'hFF, 8'hFF};
      exp = '{8'h05, 8'hC5, 8'hA5, 8'hA5};
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, CTRL_OFF, 32'(m * 2 + 1));
         apb(1'b1, DATA_OFF, 32'h0000_3CA5);
         nw++;
         wait_word(nw);
         chk({24'h0, last_pins & mask[m]}, {24'h0, exp[m]}, "pins");
         if (m == 3) begin
            chk({24'h0, last_gpio}, 32'h3C, "lower rows");
            chk({31'h0, gpio_oe_b}, 32'h0, "gpio driven");
         end
         apb(1'b1, CTRL_OFF, 32'(m * 2));
         apb(1'b1, DATA_OFF, 32'h0000_3CA5);
         nw++;
         wait_word(nw);
         wait_off;
         apb(1'b1, STAT_OFF, 32'h0000_0003);
      end
      chk(32'(syncs), 32'h5, "frame syncs");
   endtask

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      rst_b = 1'b0;
      mismatches = 0;
      checked = 0;
      nw = 0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      s_reset;
      s_base_update;
      s_disable;
      s_modes;
      end_of_test;
   end

   // the whole run needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      end_of_test;
   end
endmodule

`default_nettype wire
